// [logic/csf_status_flags.sv]
// Program status flag register with its update logic and register port
// What this block does
// - Flag layout C Z S V D H UB UA
// - Only C V Z S reach branch logic
// - Half-carry, decimal-adjust never branch conditions
// - User bits change only by explicit op or a software write to the flag register
// - Arithmetic carry is carry out of bit7 on add, borrow out of bit7 on subtract
// - Shift carry is last bit shifted out
// - Zero set when arithmetic or logic result all zeros; shifts keep it
// - Sign copies result most significant bit on every op but the user-flag op and the no-op
// - Overflow flags signed result out of range
// - Logical ops clear overflow
// - Decimal-adjust set on subtract, cleared on add
// - Half-carry from bit3 carry or borrow
`timescale 1ns/100ps
`include "csf_defines.svh"
module csf_status_flags
  import csf_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  input  wire csf_pkg::csf_req_t i_req,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  output logic [7:0]             o_result,
  output csf_pkg::csf_cond_t     o_cond
);
  import csf_pkg::*;

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] eval_flags;
  logic [7:0] eval_result;
  logic       eval_update;
  logic [7:0] result_r;

  csf_alu_eval u_eval (
    .i_req       (i_req),
    .i_flags     (flags_r),
    .o_result    (eval_result),
    .o_flags_nxt (eval_flags),
    .o_update    (eval_update)
  );

  wire flags_sel = (i_reg_addr == `CSF_FLAGS_ADDR);
  wire flags_wr  = i_reg_wr & flags_sel;

  // Software write has priority over the same cycle's result update
  assign flags_nxt = flags_wr    ? i_reg_wdata :
                     eval_update ? eval_flags  : flags_r;

  // Reset value is undefined on the part; zero is used for determinism
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      flags_r  <= `CSF_FLAGS_RESET;
      result_r <= 8'h00;
    end
    else
    begin
      flags_r  <= flags_nxt;
      if (eval_update)
      begin
        result_r <= eval_result;
      end
    end
  end

  assign o_reg_rdata = flags_sel ? flags_r : 8'h00;
  assign o_result    = result_r;
  // H, D and user bits are deliberately not routed to branch logic
  assign o_cond.carry = flags_r[`CSF_BIT_CARRY];
  assign o_cond.zero  = flags_r[`CSF_BIT_ZERO];
  assign o_cond.sign  = flags_r[`CSF_BIT_SIGN];
  assign o_cond.ovfl  = flags_r[`CSF_BIT_OVFL];

  // Reference values for the checks below, built apart from the datapath;
  // ten bits so that no signed sum of two bytes and a carry can wrap
  wire signed [9:0] ref_add = $signed({{2{i_req.a[7]}}, i_req.a})
                              + $signed({{2{i_req.b[7]}}, i_req.b})
                              + $signed({9'h0, i_req.cin});
  wire signed [9:0] ref_sub = $signed({{2{i_req.a[7]}}, i_req.a})
                              - $signed({{2{i_req.b[7]}}, i_req.b})
                              - $signed({9'h0, i_req.cin});
  wire signed [9:0] ref_v   = (i_req.op == CSF_OP_SUB) ? ref_sub : ref_add;
  wire [4:0]        ref_lo  = {1'b0, i_req.b[3:0]} + {4'h0, i_req.cin};
  wire              ref_h   = (i_req.op == CSF_OP_SUB)
                              ? ({1'b0, i_req.a[3:0]} < ref_lo)
                              : ({1'b0, i_req.a[3:0]} + ref_lo > 5'h0f);
  wire              ref_c   = {1'b0, i_req.a}
                              < ({1'b0, i_req.b} + {8'h0, i_req.cin});

  property p_sw_write;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      flags_wr |=> flags_r == $past(i_reg_wdata);
  endproperty
  a_sw_write: assert property (p_sw_write)
    else $error("software write lost");

  property p_add_carry;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_ADD) |=>
        flags_r[7] == ({1'b0, $past(i_req.a)} + {1'b0, $past(i_req.b)}
                       + {8'h00, $past(i_req.cin)}) >> 8;
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("add carry wrong");

  property p_shl_carry;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_SHL) |=>
        flags_r[7] == $past(i_req.a[7]);
  endproperty
  a_shl_carry: assert property (p_shl_carry)
    else $error("shift carry wrong");

  property p_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && (i_req.op == CSF_OP_LOGIC || i_req.op == CSF_OP_ADD))
        |=> flags_r[6] == (o_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");

  property p_sign;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op != CSF_OP_NONE && i_req.op != CSF_OP_UFLAG)
        |=> flags_r[5] == o_result[7];
  endproperty
  a_sign: assert property (p_sign)
    else $error("sign flag wrong");

  property p_logic_v;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_LOGIC) |=> !flags_r[4];
  endproperty
  a_logic_v: assert property (p_logic_v)
    else $error("logic op left overflow set");

  property p_add_v;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_ADD && i_req.a == 8'h7f
       && i_req.b == 8'h01 && !i_req.cin) |=> flags_r[4];
  endproperty
  a_add_v: assert property (p_add_v)
    else $error("overflow missed");

  property p_dadj;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && (i_req.op == CSF_OP_SUB || i_req.op == CSF_OP_ADD))
        |=> flags_r[3] == ($past(i_req.op) == CSF_OP_SUB);
  endproperty
  a_dadj: assert property (p_dadj)
    else $error("decimal adjust wrong");

  property p_half;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && (i_req.op == CSF_OP_ADD || i_req.op == CSF_OP_SUB))
        |=> flags_r[`CSF_BIT_HALF] == $past(ref_h);
  endproperty
  a_half: assert property (p_half)
    else $error("half carry wrong");

  property p_user;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op != CSF_OP_UFLAG) |=>
        flags_r[1:0] == $past(flags_r[1:0]);
  endproperty
  a_user: assert property (p_user)
    else $error("user bits changed");

  property p_sub_carry;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_SUB) |=>
        flags_r[`CSF_BIT_CARRY] == $past(ref_c);
  endproperty
  a_sub_carry: assert property (p_sub_carry)
    else $error("subtract borrow wrong");

  property p_shr_carry;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_SHR) |=>
        flags_r[`CSF_BIT_CARRY] == $past(i_req.a[0]);
  endproperty
  a_shr_carry: assert property (p_shr_carry)
    else $error("right shift carry wrong");

  property p_arith_v;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && (i_req.op == CSF_OP_ADD || i_req.op == CSF_OP_SUB))
        |=> flags_r[`CSF_BIT_OVFL] ==
              ($past(ref_v) > 10'sh07f || $past(ref_v) < -10'sh080);
  endproperty
  a_arith_v: assert property (p_arith_v)
    else $error("signed range overflow wrong");

  property p_user_op;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && i_req.op == CSF_OP_UFLAG) |=>
        flags_r[1:0] == (($past(flags_r[1:0]) | $past(i_req.user_set))
                         & ~$past(i_req.user_clr));
  endproperty
  a_user_op: assert property (p_user_op)
    else $error("user bit set or clear lost");

  // Shifts leave the zero flag alone; only arithmetic and logic move it
  property p_shift_keep_z;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      (!flags_wr && (i_req.op == CSF_OP_SHL || i_req.op == CSF_OP_SHR))
        |=> flags_r[`CSF_BIT_ZERO] == $past(flags_r[`CSF_BIT_ZERO]);
  endproperty
  a_shift_keep_z: assert property (p_shift_keep_z)
    else $error("shift changed zero flag");

  property p_rd;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      flags_sel |-> o_reg_rdata == flags_r;
  endproperty
  a_rd: assert property (p_rd)
    else $error("flag read does not show the register");

  property p_cond;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_cond == {flags_r[`CSF_BIT_CARRY], flags_r[`CSF_BIT_ZERO],
                 flags_r[`CSF_BIT_SIGN], flags_r[`CSF_BIT_OVFL]};
  endproperty
  a_cond: assert property (p_cond)
    else $error("branch conditions do not track the flags");

  c_sub:   cover property (@(posedge i_sys_clk) i_req.op == CSF_OP_SUB);
  c_shr:   cover property (@(posedge i_sys_clk) i_req.op == CSF_OP_SHR);
  c_clash: cover property (@(posedge i_sys_clk) flags_wr && eval_update);
  c_uflag: cover property (@(posedge i_sys_clk) i_req.op == CSF_OP_UFLAG);
endmodule

// [logic/csf_defines.svh]
// Address, bit positions and reset value of the status flag register
`ifndef CSF_DEFINES_SVH
`define CSF_DEFINES_SVH
`define CSF_FLAGS_ADDR   8'hfc
`define CSF_BIT_CARRY    7
`define CSF_BIT_ZERO     6
`define CSF_BIT_SIGN     5
`define CSF_BIT_OVFL     4
`define CSF_BIT_DADJ     3
`define CSF_BIT_HALF     2
`define CSF_BIT_USER_B   1
`define CSF_BIT_USER_A   0
`define CSF_FLAGS_RESET  8'h00
`endif

// [logic/csf_pkg.sv]
// Types shared by the status flag block
package csf_pkg;
  typedef enum logic [3:0] {
    CSF_OP_NONE  = 4'h0,
    CSF_OP_ADD   = 4'h1,
    CSF_OP_SUB   = 4'h2,
    CSF_OP_LOGIC = 4'h3,
    CSF_OP_SHL   = 4'h4,
    CSF_OP_SHR   = 4'h5,
    CSF_OP_UFLAG = 4'h6
  } csf_op_t;

  typedef struct packed {
    csf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [1:0] user_set;
    logic [1:0] user_clr;
  } csf_req_t;

  typedef struct packed {
    logic carry;
    logic zero;
    logic sign;
    logic ovfl;
  } csf_cond_t;
endpackage

// [logic/csf_alu_eval.sv]
// Combinational result and flag evaluation for one datapath operation
`timescale 1ns/100ps
`include "csf_defines.svh"
module csf_alu_eval
  import csf_pkg::*;
(
  input  wire csf_pkg::csf_req_t i_req,
  input  wire logic [7:0]        i_flags,
  output logic [7:0]             o_result,
  output logic [7:0]             o_flags_nxt,
  output logic                   o_update
);
  import csf_pkg::*;

  wire [8:0] sum9  = {1'b0, i_req.a} + {1'b0, i_req.b} + {8'h00, i_req.cin};
  wire [8:0] diff9 = {1'b0, i_req.a} - {1'b0, i_req.b} - {8'h00, i_req.cin};
  wire [4:0] sum5  = {1'b0, i_req.a[3:0]} + {1'b0, i_req.b[3:0]}
                     + {4'h0, i_req.cin};
  wire [4:0] diff5 = {1'b0, i_req.a[3:0]} - {1'b0, i_req.b[3:0]}
                     - {4'h0, i_req.cin};
  wire       is_add   = (i_req.op == CSF_OP_ADD);
  wire       is_sub   = (i_req.op == CSF_OP_SUB);
  wire       is_logic = (i_req.op == CSF_OP_LOGIC);
  wire       is_shl   = (i_req.op == CSF_OP_SHL);
  wire       is_shr   = (i_req.op == CSF_OP_SHR);
  wire       is_user  = (i_req.op == CSF_OP_UFLAG);
  wire       is_arith = is_add | is_sub;
  wire       is_shift = is_shl | is_shr;
  // Logical op is AND of the operands; the decoder maps others onto b
  wire [7:0] logic_res = i_req.a & i_req.b;
  wire [7:0] shl_res   = {i_req.a[6:0], i_req.cin};
  wire [7:0] shr_res   = {i_req.cin, i_req.a[7:1]};

  assign o_result = is_add   ? sum9[7:0]  :
                    is_sub   ? diff9[7:0] :
                    is_logic ? logic_res  :
                    is_shl   ? shl_res    :
                    is_shr   ? shr_res    : i_req.a;

  wire add_v = (i_req.a[7] == i_req.b[7]) & (sum9[7] != i_req.a[7]);
  wire sub_v = (i_req.a[7] != i_req.b[7]) & (diff9[7] != i_req.a[7]);
  // Shift overflow: sign changed by the shift
  wire shf_v = o_result[7] ^ i_req.a[7];

  wire c_nxt = is_add ? sum9[8] :
               is_sub ? diff9[8] :
               is_shl ? i_req.a[7] :
               is_shr ? i_req.a[0] : i_flags[`CSF_BIT_CARRY];
  wire v_nxt = is_add ? add_v : is_sub ? sub_v :
               is_shift ? shf_v :
               is_logic ? 1'b0 : i_flags[`CSF_BIT_OVFL];
  wire z_nxt = (is_arith | is_logic) ? (o_result == 8'h00)
               : i_flags[`CSF_BIT_ZERO];
  wire s_nxt = (is_arith | is_logic | is_shift) ? o_result[7]
               : i_flags[`CSF_BIT_SIGN];
  wire d_nxt = is_sub ? 1'b1 : is_add ? 1'b0
               : i_flags[`CSF_BIT_DADJ];
  wire h_nxt = is_add ? sum5[4] : is_sub ? diff5[4]
               : i_flags[`CSF_BIT_HALF];
  // User bits move only on an explicit set/clear op
  wire [1:0] u_nxt = is_user ?
    ((i_flags[1:0] | i_req.user_set) & ~i_req.user_clr) : i_flags[1:0];

  assign o_flags_nxt = {c_nxt, z_nxt, s_nxt, v_nxt, d_nxt, h_nxt, u_nxt};
  assign o_update    = (i_req.op != CSF_OP_NONE);
endmodule

// [dv/csf_status_flags_tb.sv]
// Self-checking bench for the status flag register and its update logic
`timescale 1ns/100ps
module csf_status_flags_tb;
  import csf_pkg::*;
  typedef struct packed {
    logic [7:0] res;
    logic [7:0] rd;
    logic [3:0] cnd;
  } csf_note_t;
  logic       i_sys_clk   = 1'b0;
  logic       i_rst_b     = 1'b0;
  csf_req_t   i_req       = '0;
  logic [7:0] i_reg_addr  = 8'hfc;
  logic       i_reg_wr    = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic [7:0] o_result;
  csf_cond_t  o_cond;
  csf_note_t  notes[$];
  csf_note_t  n;
  logic [7:0] mf = 8'h00;
  logic [7:0] mres = 8'h00;
  logic [31:0] rng = 32'd3060;
  int         failures = 0;
  int         checks_done = 0;
  csf_status_flags u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
    .i_req(i_req), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_result(o_result), .o_cond(o_cond));
  always #4 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic cmp8(logic [7:0] got, logic [7:0] exp, string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp4(logic [3:0] got, logic [3:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t cond: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Expected flags come from an independent model of each operation
  task automatic drive(csf_op_t op, logic [7:0] a, logic [7:0] b,
    logic cin, logic [1:0] us, logic [1:0] uc, logic wr, logic [7:0] ad,
    logic [7:0] wd);
    logic [8:0] s;
    logic [7:0] f;
    logic [7:0] r;
    logic       ad_fl;
    @(negedge i_sys_clk);
    f = mf;
    r = mres;
    ad_fl = (ad == 8'hfc);
    s = (op == CSF_OP_ADD) ? {1'b0, a} + {1'b0, b} + {8'h00, cin}
                           : {1'b0, a} - {1'b0, b} - {8'h00, cin};
    case (op)
      CSF_OP_ADD, CSF_OP_SUB:
      begin
        r = s[7:0];
        f[7] = s[8];
        f[4] = (op == CSF_OP_ADD) ? (a[7] == b[7] && r[7] != a[7])
                                  : (a[7] != b[7] && r[7] != a[7]);
        f[3] = (op == CSF_OP_SUB);
        f[2] = (op == CSF_OP_ADD) ? ({1'b0, a[3:0]} + b[3:0] + cin > 5'h0f)
                                  : ({1'b0, a[3:0]} < b[3:0] + cin);
      end
      CSF_OP_LOGIC:
      begin
        r = a & b;
        f[4] = 1'b0;
      end
      CSF_OP_SHL:
      begin
        r = {a[6:0], cin};
        f[7] = a[7];
        f[4] = r[7] ^ a[7];
      end
      CSF_OP_SHR:
      begin
        r = {cin, a[7:1]};
        f[7] = a[0];
        f[4] = r[7] ^ a[7];
      end
      CSF_OP_UFLAG:
      begin
        // The result register still loads, passing the first operand
        r = a;
        f[1:0] = (f[1:0] | us) & ~uc;
      end
      default: ;
    endcase
    if (op inside {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC})
      f[6] = (r == 8'h00);
    if (op inside {[CSF_OP_ADD:CSF_OP_SHR]})
      f[5] = r[7];
    if (wr && ad_fl)
      f = wd;
    mres = r;
    mf = f;
    i_req = '{op: op, a: a, b: b, cin: cin, user_set: us, user_clr: uc};
    i_reg_wr = wr;
    i_reg_addr = ad;
    i_reg_wdata = wd;
    notes.push_back('{res: r, rd: ad_fl ? f : 8'h00, cnd: f[7:4]});
  endtask
  // Each edge after a drive carries exactly one note from the driver
  always @(posedge i_sys_clk)
    if (i_rst_b && notes.size() > 0)
    begin
      #1;
      n = notes.pop_front();
      cmp8(o_reg_rdata, n.rd, "flags");
      cmp4(o_cond, n.cnd);
      cmp8(o_result, n.res, "result");
    end
  initial
  begin
    logic [31:0] v;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    drive(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_ADD, 8'h7f, 8'h01, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_SUB, 8'h80, 8'h01, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_SUB, 8'h00, 8'h01, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_ADD, 8'hff, 8'h01, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_ADD, 8'h0f, 8'h00, 1'b1, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_ADD, 8'hff, 8'hff, 1'b0, 2'h0, 2'h0,
          1'b1, 8'hfc, 8'h03);
    drive(CSF_OP_SUB, 8'h10, 8'h20, 1'b0, 2'h0, 2'h0,
          1'b1, 8'hfb, 8'h00);
    drive(CSF_OP_UFLAG, 8'h00, 8'h00, 1'b0, 2'h2, 2'h1,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_UFLAG, 8'h00, 8'h00, 1'b0, 2'h3, 2'h3,
          1'b0, 8'hfc, 8'h00);
    drive(CSF_OP_LOGIC, 8'ha5, 8'h5a, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    repeat (60)
    begin
      v = xs();
      drive(csf_op_t'(4'(v % 6 + 1)), v[15:8], v[23:16],
            v[24], v[26:25], v[28:27], v[29] & v[30],
            v[31] ? 8'hfc : v[7:0], v[19:12]);
    end
    drive(CSF_OP_NONE, 8'h00, 8'h00, 1'b0, 2'h0, 2'h0,
          1'b0, 8'hfc, 8'h00);
    for (int i = 0; i < 10 && notes.size() > 0; i++)
      @(posedge i_sys_clk);
    repeat (2) @(posedge i_sys_clk);
    if (notes.size() > 0)
      failures++;
    conclude();
  end
endmodule
